// File: swctl_ctrl.sv
// Device control word and the logic it steers
// Functional notes
// - Bit 8 selects a 122ns (clear) or 244ns (set) input frame pulse and the device checks for that width.
// - Bit 6 aligns the frame boundary to the falling (clear) or rising (set) edge of the 8 MHz input clock.
// - Bit 5 inverts both the 8MHz and 16MHz output clocks when set.
// - Bit 4 arms block programming of both connection memories when set.
// - Serial outputs carry stream data only when the drive-enable pin and bit 3 are both one; else they drive high or float per the off-state select.
// - The three-bit memory select steers later host memory accesses to one of four memories for codes 0 to 3; codes 4 to 7 select none.
`timescale 1ns/10ps
module swctl_ctrl #(
  parameter int N_STREAMS = 16,
  parameter int N_BUF     = 2
) (
  // Clock and reset
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst,
  // Host port
  input  wire logic                          i_cs,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  input  wire logic [swctl_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [15:0]                   i_wdata,
  output logic      [15:0]                   o_rdata,
  output logic                               o_rd_hit,
  // Timing pins
  input  wire logic                          i_clock_in_8m,
  input  wire logic                          i_frame_pulse_in,
  input  wire logic                          i_output_drive_enable_pin,
  input  wire logic                          i_local_off_state_select,
  input  wire logic                          i_backplane_off_state_select,
  // Stream data from the switch
  input  wire logic [N_STREAMS-1:0]          i_local_data,
  input  wire logic [N_STREAMS-1:0]          i_backplane_data,
  input  wire logic [N_BUF-1:0]              i_local_buf_ctrl,
  input  wire logic [N_BUF-1:0]              i_backplane_buf_ctrl,
  input  wire logic                          i_clock_8m_gen,
  input  wire logic                          i_clock_16m_gen,
  // Control outputs
  output logic                               o_frame_boundary,
  output logic                               o_frame_pulse_ok,
  output logic                               o_clock_out_8m,
  output logic                               o_clock_out_16m,
  output logic                               o_block_program_armed,
  output logic      [2:0]                    o_memory_select,
  output logic                               o_local_cm_sel,
  output logic                               o_backplane_cm_sel,
  output logic                               o_local_dm_sel,
  output logic                               o_backplane_dm_sel,
  output logic                               o_mem_write_allowed,
  // Serial outputs
  output logic      [N_STREAMS-1:0]          o_local_serial_out,
  output logic      [N_STREAMS-1:0]          o_local_serial_out_oe,
  output logic      [N_STREAMS-1:0]          o_backplane_serial_out,
  output logic      [N_STREAMS-1:0]          o_backplane_serial_out_oe,
  output logic      [N_BUF-1:0]              o_local_buffer_ctrl_out,
  output logic      [N_BUF-1:0]              o_backplane_buffer_ctrl_out
);
  logic [15:0] ctrl_reg;
  logic [4:0]  sync1_reg;
  logic [4:0]  sync2_reg;
  logic        clk_d_reg;
  logic        fp_d_reg;
  logic [7:0]  fp_cnt_reg;
  logic        outputs_en;
  logic        wr_hit;

  function automatic logic width_ok(input logic [7:0] cnt, input logic wide);
    if (wide) begin
      width_ok = (cnt >= 8'(swctl_pkg::FP_WIDE_CYC - 1)) && (cnt <= 8'(swctl_pkg::FP_WIDE_CYC + 1));
    end else begin
      width_ok = (cnt >= 8'(swctl_pkg::FP_NARROW_CYC - 1)) && (cnt <= 8'(swctl_pkg::FP_NARROW_CYC + 1));
    end
  endfunction

  // ***************************
  // Register access
  // ***************************
  assign wr_hit = i_cs && i_wr && (i_addr == swctl_pkg::CTRL_WORD_ADDR);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl_reg <= swctl_pkg::CTRL_WORD_RESET;
    end else if (wr_hit) begin
      ctrl_reg <= i_wdata & swctl_pkg::CTRL_WORD_MASK;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rdata  <= 16'h0000;
      o_rd_hit <= 1'b0;
    end else if (i_cs && i_rd && (i_addr == swctl_pkg::CTRL_WORD_ADDR)) begin
      o_rdata  <= ctrl_reg;
      o_rd_hit <= 1'b1;
    end else begin
      o_rdata  <= 16'h0000;
      o_rd_hit <= 1'b0;
    end
  end

  // ***************************
  // Pin synchronisers
  // ***************************
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else begin
      sync1_reg <= {i_backplane_off_state_select, i_local_off_state_select,
                    i_output_drive_enable_pin, i_frame_pulse_in, i_clock_in_8m};
      sync2_reg <= sync1_reg;
    end
  end

  // ***************************
  // Frame timing
  // ***************************
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      clk_d_reg        <= 1'b0;
      fp_d_reg         <= 1'b0;
      o_frame_boundary <= 1'b0;
    end else begin
      clk_d_reg <= sync2_reg[0];
      fp_d_reg  <= sync2_reg[1];
      if (ctrl_reg[swctl_pkg::INPUT_CLOCK_POLARITY_BIT]) begin
        o_frame_boundary <= sync2_reg[1] && sync2_reg[0] && !clk_d_reg;
      end else begin
        o_frame_boundary <= sync2_reg[1] && !sync2_reg[0] && clk_d_reg;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      fp_cnt_reg       <= 8'h00;
      o_frame_pulse_ok <= 1'b0;
    end else if (sync2_reg[1]) begin
      if (fp_cnt_reg != 8'hff) begin
        fp_cnt_reg <= fp_cnt_reg + 8'h01;
      end
    end else begin
      fp_cnt_reg <= 8'h00;
      if (fp_d_reg) begin
        o_frame_pulse_ok <= width_ok(fp_cnt_reg, ctrl_reg[swctl_pkg::FRAME_PULSE_WIDTH_BIT]);
      end
    end
  end

  // ***************************
  // Output clocks and modes
  // ***************************
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_clock_out_8m  <= 1'b0;
      o_clock_out_16m <= 1'b0;
    end else begin
      o_clock_out_8m  <= i_clock_8m_gen ^ ctrl_reg[swctl_pkg::OUTPUT_CLOCK_POLARITY_BIT];
      o_clock_out_16m <= i_clock_16m_gen ^ ctrl_reg[swctl_pkg::OUTPUT_CLOCK_POLARITY_BIT];
    end
  end

  assign o_block_program_armed = ctrl_reg[swctl_pkg::BLOCK_PROGRAM_MODE_BIT];
  assign o_memory_select       = ctrl_reg[swctl_pkg::MEM_SEL_LSB +: swctl_pkg::MEM_SEL_W];
  assign o_local_cm_sel        = o_memory_select == swctl_pkg::SWCTL_MS_LOCAL_CM;
  assign o_backplane_cm_sel    = o_memory_select == swctl_pkg::SWCTL_MS_BACK_CM;
  assign o_local_dm_sel        = o_memory_select == swctl_pkg::SWCTL_MS_LOCAL_DM;
  assign o_backplane_dm_sel    = o_memory_select == swctl_pkg::SWCTL_MS_BACK_DM;
  assign o_mem_write_allowed   = o_local_cm_sel || o_backplane_cm_sel;

  // ***************************
  // Output gating
  // ***************************
  assign outputs_en = sync2_reg[2] && ctrl_reg[swctl_pkg::OUTPUT_STANDBY_BIT];

  swctl_out_gate #(.N_STREAMS(N_STREAMS), .N_BUF(N_BUF)) u_local_gate (
    .i_core_clk       (i_core_clk),
    .i_rst            (i_rst),
    .i_enable         (outputs_en),
    .i_off_state_high (sync2_reg[3]),
    .i_data           (i_local_data),
    .i_buf_ctrl       (i_local_buf_ctrl),
    .o_data           (o_local_serial_out),
    .o_data_oe        (o_local_serial_out_oe),
    .o_buf_ctrl       (o_local_buffer_ctrl_out)
  );

  swctl_out_gate #(.N_STREAMS(N_STREAMS), .N_BUF(N_BUF)) u_backplane_gate (
    .i_core_clk       (i_core_clk),
    .i_rst            (i_rst),
    .i_enable         (outputs_en),
    .i_off_state_high (sync2_reg[4]),
    .i_data           (i_backplane_data),
    .i_buf_ctrl       (i_backplane_buf_ctrl),
    .o_data           (o_backplane_serial_out),
    .o_data_oe        (o_backplane_serial_out_oe),
    .o_buf_ctrl       (o_backplane_buffer_ctrl_out)
  );
endmodule // swctl_ctrl

// File: swctl_ctrl_props.sv
// Checker for the control word block
`timescale 1ns/10ps
module swctl_ctrl_props #(
  parameter int N_STREAMS = 16,
  parameter int N_BUF     = 2
) (
  input wire logic                 i_core_clk,
  input wire logic                 i_rst,
  input wire logic                 i_cs,
  input wire logic                 i_wr,
  input wire logic                 i_rd,
  input wire logic [14:0]          i_addr,
  input wire logic [15:0]          i_wdata,
  input wire logic [15:0]          o_rdata,
  input wire logic                 o_rd_hit,
  input wire logic                 i_clock_8m_gen,
  input wire logic                 o_clock_out_8m,
  input wire logic                 o_block_program_armed,
  input wire logic [2:0]           o_memory_select,
  input wire logic                 o_mem_write_allowed,
  input wire logic [N_STREAMS-1:0] o_local_serial_out,
  input wire logic [N_BUF-1:0]     o_local_buffer_ctrl_out
);
  logic [15:0] ctl_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) ctl_reg <= 16'h0000;
    else if (i_cs && i_wr && i_addr == 15'h0000) ctl_reg <= i_wdata & swctl_pkg::CTRL_WORD_MASK;
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence host_wr; i_cs && i_wr && i_addr == 15'h0000; endsequence
  sequence host_rd; i_cs && i_rd && i_addr == 15'h0000; endsequence
  prog_arm_a: assert property (host_wr |=> o_block_program_armed == $past(i_wdata[4]))
    else $error("armed flag wrong");
  mem_sel_a: assert property (host_wr |=> o_memory_select == $past(i_wdata[2:0]))
    else $error("memory select wrong");
  mem_dec_a: assert property (o_mem_write_allowed == (o_memory_select < 3'h2))
    else $error("write permit wrong");
  rd_data_a: assert property (host_rd |=> o_rd_hit && o_rdata == $past(ctl_reg))
    else $error("read data wrong");
  rd_only_a: assert property (o_rd_hit |-> $past(i_cs) && $past(i_rd) && $past(i_addr) == 15'h0000)
    else $error("stray read hit");
  rsv_zero_a: assert property (o_rd_hit |-> o_rdata[7] == 1'b0 && o_rdata[15:9] == 7'h00)
    else $error("reserved bits set");
  clk_out_a: assert property (!$past(i_rst) |-> o_clock_out_8m == ($past(i_clock_8m_gen) ^ $past(ctl_reg[5])))
    else $error("output clock wrong");
  off_out_a: assert property (!$past(i_rst) && !$past(ctl_reg[3]) |-> o_local_serial_out == '1 && o_local_buffer_ctrl_out == '0)
    else $error("standby outputs wrong");
endmodule // swctl_ctrl_props
bind swctl_ctrl swctl_ctrl_props #(.N_STREAMS(N_STREAMS), .N_BUF(N_BUF)) u_props (.*);

// File: swctl_host.sv
// Host port model issuing control word accesses
`timescale 1ns/10ps
module swctl_host (
  // Clock and read answer
  input  wire logic        i_core_clk,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_rd_hit,
  // Host strobes
  output logic             o_cs,
  output logic             o_wr,
  output logic             o_rd,
  output logic      [14:0] o_addr,
  output logic      [15:0] o_wdata
);
  initial {o_cs, o_wr, o_rd, o_addr, o_wdata} = {3'h0, 15'h7fff, 16'h0000};
  task automatic wr_word(input logic [15:0] d);
    @(posedge i_core_clk);
    {o_cs, o_wr, o_addr, o_wdata} <= {2'h3, 15'h0000, d & 16'hff7f};
    @(posedge i_core_clk);
    {o_cs, o_wr, o_addr, o_wdata} <= {2'h0, 15'h7fff, ~d};
  endtask
  task automatic rd_word(input logic [14:0] a, output logic [15:0] d, output logic hit);
    hit = 1'b0;
    d = 16'h0000;
    @(posedge i_core_clk);
    {o_cs, o_rd, o_addr} <= {2'h3, a};
    // Hold the request until the answer is sampled or four edges pass
    for (int i = 0; i < 4 && !hit; i++) begin
      @(posedge i_core_clk);
      if (i_rd_hit === 1'b1) begin
        hit = 1'b1;
        d = i_rdata;
      end
    end
    {o_cs, o_rd, o_addr} <= {2'h0, ~a};
  endtask
endmodule // swctl_host

// File: swctl_out_gate.sv
// Output gating for serial streams and buffer controls
`timescale 1ns/10ps
module swctl_out_gate #(
  parameter int N_STREAMS = 16,
  parameter int N_BUF     = 2
) (
  // Clock and reset
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst,
  // Control
  input  wire logic                 i_enable,
  input  wire logic                 i_off_state_high,
  // Stream data from the switch
  input  wire logic [N_STREAMS-1:0] i_data,
  input  wire logic [N_BUF-1:0]     i_buf_ctrl,
  // Pin drive
  output logic      [N_STREAMS-1:0] o_data,
  output logic      [N_STREAMS-1:0] o_data_oe,
  output logic      [N_BUF-1:0]     o_buf_ctrl
);
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_data     <= '1;
      o_data_oe  <= '0;
      o_buf_ctrl <= '0;
    end else if (i_enable) begin
      o_data     <= i_data;
      o_data_oe  <= '1;
      o_buf_ctrl <= i_buf_ctrl;
    end else begin
      o_data     <= '1;
      o_data_oe  <= {N_STREAMS{i_off_state_high}};
      o_buf_ctrl <= '0;
    end
  end
endmodule // swctl_out_gate

// File: swctl_pkg.sv
// Package for the switch control register block
package swctl_pkg;
  // Register address and width
  localparam int          ADDR_W           = 15;
  localparam logic [14:0] CTRL_WORD_ADDR   = 15'h0000;
  localparam logic [15:0] CTRL_WORD_RESET  = 16'h0000;
  // Field positions
  localparam int FRAME_PULSE_WIDTH_BIT     = 8;
  localparam int RESERVED_LOW_BIT          = 7;
  localparam int INPUT_CLOCK_POLARITY_BIT  = 6;
  localparam int OUTPUT_CLOCK_POLARITY_BIT = 5;
  localparam int BLOCK_PROGRAM_MODE_BIT    = 4;
  localparam int OUTPUT_STANDBY_BIT        = 3;
  localparam int MEM_SEL_LSB               = 0;
  localparam int MEM_SEL_W                 = 3;
  // Writable bits mask: 15-9 and 7 reserved read zero
  localparam logic [15:0] CTRL_WORD_MASK   = 16'h017f;
  // Frame pulse widths
  localparam int FP_NARROW_NS              = 122;
  localparam int FP_WIDE_NS                = 244;
  localparam int CLK_PERIOD_NS             = 50;
  localparam int FP_NARROW_CYC             = (FP_NARROW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FP_WIDE_CYC               = (FP_WIDE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Memory select codes
  typedef enum logic [2:0] {
    SWCTL_MS_LOCAL_CM  = 3'h0,
    SWCTL_MS_BACK_CM   = 3'h1,
    SWCTL_MS_LOCAL_DM  = 3'h2,
    SWCTL_MS_BACK_DM   = 3'h3
  } swctl_mem_sel_t;
endpackage

// File: testbench.sv
// Self-checking bench for the control word block
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; $display("wrong value t=%0t %h %h", $time, a, b); end end
module testbench;
  logic        i_core_clk = 1'b0, i_rst = 1'b1, ok;
  logic        i_clock_in_8m, i_frame_pulse_in, i_output_drive_enable_pin, i_local_off_state_select;
  logic        i_backplane_off_state_select, i_clock_8m_gen, i_clock_16m_gen, i_cs, i_wr, i_rd, o_rd_hit;
  logic        o_frame_boundary, o_frame_pulse_ok, o_clock_out_8m, o_clock_out_16m, o_block_program_armed;
  logic        o_local_cm_sel, o_backplane_cm_sel, o_local_dm_sel, o_backplane_dm_sel, o_mem_write_allowed;
  logic [1:0]  i_local_buf_ctrl, i_backplane_buf_ctrl, o_local_buffer_ctrl_out, o_backplane_buffer_ctrl_out;
  logic [2:0]  o_memory_select;
  logic [14:0] i_addr;
  logic [15:0] i_wdata, o_rdata, rd, i_local_data, i_backplane_data, o_local_serial_out, o_local_serial_out_oe;
  logic [15:0] o_backplane_serial_out, o_backplane_serial_out_oe;
  int          err_count = 0, samples_checked = 0;
  logic [1:0]  edge_seen [2] = '{2'h0, 2'h0};
  swctl_ctrl dut (.*);
  swctl_host host (.i_core_clk, .i_rdata(o_rdata), .i_rd_hit(o_rd_hit), .o_cs(i_cs), .o_wr(i_wr), .o_rd(i_rd),
    .o_addr(i_addr), .o_wdata(i_wdata));
  assign i_backplane_data = ~i_local_data;
  assign i_local_buf_ctrl = i_local_data[1:0];
  assign i_backplane_buf_ctrl = ~i_local_data[1:0];
  assign i_backplane_off_state_select = ~i_local_off_state_select;
  assign i_clock_16m_gen = ~i_clock_8m_gen;
  always #25 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) i_clock_in_8m <= ~i_clock_in_8m;
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic rd_chk(input logic [14:0] a, input logic [15:0] exp);
    host.rd_word(a, rd, ok);
    `CHK(ok, (a == 15'h0000))
    if (a == 15'h0000 && !ok) complete_run();
    `CHK(rd, exp)
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {i_clock_in_8m, i_frame_pulse_in, i_output_drive_enable_pin, i_local_off_state_select, i_clock_8m_gen} = 5'h0;
    i_local_data = 16'ha5a5;
    cyc(20);
    i_rst <= 1'b0;
    rd_chk(15'h0000, 16'h0000);
    host.wr_word(16'hff7f);
    rd_chk(15'h0000, 16'h017f);
    rd_chk(15'h0001, 16'h0000);
    $display("register test done");
    i_clock_8m_gen <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      host.wr_word({10'h000, j[0], j[1], 2'h0, j[1:0]});
      cyc(2);
      `CHK(o_clock_out_8m, ~j[0])
      `CHK(o_clock_out_16m, j[0])
      `CHK(o_block_program_armed, j[1])
      `CHK(({o_local_cm_sel, o_backplane_cm_sel, o_local_dm_sel, o_backplane_dm_sel}), 4'h8 >> j)
      `CHK(o_mem_write_allowed, j < 2)
    end
    host.wr_word(16'h0004);
    cyc(1);
    `CHK(({o_local_cm_sel, o_backplane_cm_sel, o_local_dm_sel, o_backplane_dm_sel}), 4'h0)
    `CHK(o_mem_write_allowed, 1'b0)
    $display("mode test done");
    for (int k = 0; k < 8; k++) begin
      host.wr_word({12'h000, k[0], 3'h0});
      i_output_drive_enable_pin <= k[1];
      i_local_off_state_select <= k[2];
      cyc(5);
      `CHK(o_local_serial_out, (k[0] & k[1]) ? 16'ha5a5 : 16'hffff)
      `CHK(o_backplane_serial_out, (k[0] & k[1]) ? 16'h5a5a : 16'hffff)
      `CHK(o_local_serial_out_oe, (k[0] & k[1] | k[2]) ? 16'hffff : 16'h0000)
      `CHK(o_backplane_serial_out_oe, (k[0] & k[1] | ~k[2]) ? 16'hffff : 16'h0000)
      `CHK(o_local_buffer_ctrl_out, (k[0] & k[1]) ? 2'h1 : 2'h0)
      `CHK(o_backplane_buffer_ctrl_out, (k[0] & k[1]) ? 2'h2 : 2'h0)
    end
    $display("gating test done");
    i_rst <= 1'b1;
    cyc(3);
    i_rst <= 1'b0;
    `CHK(o_local_serial_out, 16'hffff)
    `CHK(o_local_serial_out_oe, 16'h0000)
    rd_chk(15'h0000, 16'h0000);
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      host.wr_word({7'h00, k[1], 1'b0, k[0], 6'h00});
      i_frame_pulse_in <= 1'b1;
      for (int c = 0; c < 16; c++) begin
        @(posedge i_core_clk);
        if (c == (k[1] ? (k[0] ? 2 : 4) : (k[0] ? 7 : 2))) i_frame_pulse_in <= 1'b0;
        if (o_frame_boundary === 1'b1) edge_seen[k[0]][i_clock_in_8m] = 1'b1;
      end
      `CHK(o_frame_pulse_ok, ~k[0])
    end
    // Each polarity keeps one clock phase, and the two phases differ
    `CHK(edge_seen[0] ^ edge_seen[1], 2'h3)
    `CHK(^edge_seen[0], 1'b1)
    $display("frame test done");
    complete_run();
  end
endmodule // testbench
